// >>> include/spz_regs.svh
`ifndef SPZ_REGS_SVH
`define SPZ_REGS_SVH

// register indices; byte address is four times the index
`define SPZ_IDX_CTRL 8'h98
`define SPZ_IDX_BUF 8'h99
`define SPZ_IDX_PWR 8'hA0
`define SPZ_IDX_BAUD 8'hA1
`define SPZ_IDX_IRQ_STAT 8'hA2
`define SPZ_IDX_IRQ_MASK 8'hA3

// serial control fields
`define SPZ_CTRL_MODE_HI 7
`define SPZ_CTRL_MODE_LO 6
`define SPZ_CTRL_MP 5
`define SPZ_CTRL_REN 4
`define SPZ_CTRL_TX9 3
`define SPZ_CTRL_RX9 2
`define SPZ_CTRL_TXF 1
`define SPZ_CTRL_RXF 0

// power control fields
`define SPZ_PWR_DBL 7
`define SPZ_PWR_FESEL 6

// interrupt status and mask fields
`define SPZ_IRQ_TX 0
`define SPZ_IRQ_RX 1
`define SPZ_IRQ_FE 2

// reset values
`define SPZ_CTRL_RST 8'h00
`define SPZ_PWR_RST 8'h00
`define SPZ_BAUD_RST 8'h00
`define SPZ_IRQ_RST 3'h0

// oscillator periods per bit, and samples per asynchronous bit
`define SPZ_M0_BIT_SLOW 12
`define SPZ_M0_BIT_FAST 4
`define SPZ_M2_BIT_SLOW 64
`define SPZ_M2_BIT_FAST 32
`define SPZ_OVERSAMPLE 16

`endif

// >>> include/spz_pkg.sv
package spz_pkg;

	typedef enum logic [1:0] {
		SPZ_MODE_SHIFT,
		SPZ_MODE_UART8,
		SPZ_MODE_FIXED9,
		SPZ_MODE_VAR9
	} spz_mode_t;

	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic multiproc_select;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
	} spz_ctrl_t;

	typedef struct packed {
		logic frame_err;
		logic rx_done;
		logic tx_done;
	} spz_irq_t;

	typedef enum logic [1:0] {
		SPZ_TX_IDLE,
		SPZ_TX_ASYNC,
		SPZ_TX_SYNC
	} spz_tx_state_t;

	typedef enum logic [1:0] {
		SPZ_RX_IDLE,
		SPZ_RX_START,
		SPZ_RX_ASYNC,
		SPZ_RX_SYNC
	} spz_rx_state_t;

endpackage : spz_pkg

// >>> logic/spz_rate_gen.sv
`timescale 1ns/1ps
`include "spz_regs.svh"

module spz_rate_gen #(
	parameter int CNT_W = 9
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic restart,
	input wire spz_pkg::spz_mode_t mode,
	input wire logic fast,
	input wire logic [7:0] baud_div,
	output logic tick
);
	import spz_pkg::*;

	localparam logic [CNT_W-1:0] M0_SLOW = CNT_W'(`SPZ_M0_BIT_SLOW / 2);
	localparam logic [CNT_W-1:0] M0_FAST = CNT_W'(`SPZ_M0_BIT_FAST / 2);
	localparam logic [CNT_W-1:0] M2_SLOW = CNT_W'(`SPZ_M2_BIT_SLOW / `SPZ_OVERSAMPLE);
	localparam logic [CNT_W-1:0] M2_FAST = CNT_W'(`SPZ_M2_BIT_FAST / `SPZ_OVERSAMPLE);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] var_period;
	logic at_end;

	// mode 0: one tick per half bit; async modes: sixteen ticks per bit
	assign var_period = CNT_W'(baud_div) + CNT_W'(1);
	assign period = (mode == SPZ_MODE_SHIFT) ? (fast ? M0_FAST : M0_SLOW) :
		(mode == SPZ_MODE_FIXED9) ? (fast ? M2_FAST : M2_SLOW) : var_period;
	// at or past the end, so a shorter period after a mode change cannot wrap the count
	assign at_end = (cnt_ff >= period - CNT_W'(1));
	assign tick = ce & at_end & ~restart;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_ff <= '0;
		end else if (ce) begin
			cnt_ff <= (restart || at_end) ? '0 : cnt_ff + CNT_W'(1);
		end
	end

endmodule : spz_rate_gen

// >>> logic/spz_serial_port.sv
`timescale 1ns/1ps
`include "spz_regs.svh"

module spz_serial_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic txd,
	input wire logic rxd_i,
	output logic rxd_o,
	output logic rxd_oe
);
	import spz_pkg::*;

	// bus slave
	logic ack_ff;
	logic [31:0] readdata_ff;
	logic [7:0] rdata;
	wire bus_req = avs_read | avs_write;
	wire [7:0] idx = avs_address[9:2];
	wire addr_ok = (avs_address[1:0] == 2'h0);
	wire hit_ctrl = addr_ok && (idx == `SPZ_IDX_CTRL);
	wire hit_buf = addr_ok && (idx == `SPZ_IDX_BUF);
	wire hit_pwr = addr_ok && (idx == `SPZ_IDX_PWR);
	wire hit_baud = addr_ok && (idx == `SPZ_IDX_BAUD);
	wire hit_stat = addr_ok && (idx == `SPZ_IDX_IRQ_STAT);
	wire hit_mask = addr_ok && (idx == `SPZ_IDX_IRQ_MASK);
	wire wr_take = avs_write & ack_ff & avs_byteenable[0];
	wire rd_load = avs_read & ~ack_ff;
	wire [7:0] wdat = avs_writedata[7:0];
	wire wr_ctrl = wr_take & hit_ctrl;
	wire wr_buf = wr_take & hit_buf;

	assign avs_waitrequest = bus_req & ~ack_ff;
	assign avs_readdata = readdata_ff;

	// registers
	spz_ctrl_t ctrl_ff;
	spz_ctrl_t nxt_ctrl;
	logic fe_ff;
	logic nxt_fe;
	logic dbl_ff;
	logic fesel_ff;
	logic [7:0] baud_ff;
	logic [7:0] rxbuf_ff;
	spz_irq_t stat_ff;
	spz_irq_t mask_ff;
	spz_irq_t events;
	localparam logic [7:0] PWR_RST = `SPZ_PWR_RST;

	wire spz_mode_t mode = spz_mode_t'({ctrl_ff.mode_select_high, ctrl_ff.mode_select_low});
	wire mp = ctrl_ff.multiproc_select;
	wire ren = ctrl_ff.rx_enable;
	wire ctrl_top = fesel_ff ? fe_ff : ctrl_ff.mode_select_high;

	assign rdata = hit_ctrl ? {ctrl_top, ctrl_ff[6:0]} :
		hit_buf ? rxbuf_ff :
		hit_pwr ? {dbl_ff, fesel_ff, 6'h00} :
		hit_baud ? baud_ff :
		hit_stat ? {5'h00, stat_ff} :
		hit_mask ? {5'h00, mask_ff} : 8'h00;

	// pin synchroniser
	logic rxd_s1_ff;
	logic rxd_s2_ff;
	logic rxd_prev_ff;

	// rate generator
	logic tick;
	logic restart;

	// transmitter
	spz_tx_state_t tx_state_ff;
	spz_tx_state_t nxt_tx_state;
	logic [10:0] tx_sr_ff;
	logic [10:0] nxt_tx_sr;
	logic [3:0] tx_bit_ff;
	logic [3:0] nxt_tx_bit;
	logic [3:0] tx_sub_ff;
	logic [3:0] nxt_tx_sub;
	logic tx_phase_ff;
	logic nxt_tx_phase;
	logic tx_done_set;

	// receiver
	spz_rx_state_t rx_state_ff;
	spz_rx_state_t nxt_rx_state;
	logic [9:0] rx_bits_ff;
	logic [9:0] nxt_rx_bits;
	logic [9:0] rx_frame;
	logic [3:0] rx_bit_ff;
	logic [3:0] nxt_rx_bit;
	logic [3:0] rx_sub_ff;
	logic [3:0] nxt_rx_sub;
	logic rx_phase_ff;
	logic nxt_rx_phase;
	logic rx_finish;

	// pin drivers
	logic txd_ff;
	logic rxd_o_ff;
	logic rxd_oe_ff;
	logic nxt_txd;
	logic nxt_rxd_o;
	logic nxt_rxd_oe;

	wire tx_idle = (tx_state_ff == SPZ_TX_IDLE);
	wire rx_idle = (rx_state_ff == SPZ_RX_IDLE);
	wire shift_mode = (mode == SPZ_MODE_SHIFT);
	wire tx_start = wr_buf & tx_idle & (rx_state_ff != SPZ_RX_SYNC);
	wire [3:0] tx_last = (mode == SPZ_MODE_UART8) ? 4'h9 : 4'hA;
	wire tx_ninth = (mode == SPZ_MODE_UART8) ? 1'b1 : ctrl_ff.tx_ninth_bit;
	wire rx_sync_start = ren & shift_mode & rx_idle & tx_idle & ~ctrl_ff.rx_done_flag;
	wire rx_async_start = ren & ~shift_mode & rx_idle & rxd_prev_ff & ~rxd_s2_ff;
	wire [3:0] rx_last = (mode == SPZ_MODE_UART8) ? 4'h8 : 4'h9;
	wire rx_stop = (mode == SPZ_MODE_UART8) ? rx_frame[8] : rx_frame[9];
	wire rx_ninth = rx_frame[8];
	wire async_done = rx_finish & ~shift_mode;
	wire fe_set = async_done & ~rx_stop;
	wire rx_accept = rx_finish & (shift_mode ? 1'b1 :
		(mode == SPZ_MODE_UART8) ? (~mp | rx_stop) :
		(~mp | rx_ninth));
	wire rx9_load = async_done & (mode == SPZ_MODE_UART8 ? ~mp : 1'b1);
	wire rx9_val = (mode == SPZ_MODE_UART8) ? rx_stop : rx_ninth;

	assign restart = (tx_start & shift_mode) | rx_sync_start;

	spz_rate_gen #(
		.CNT_W(9)
	) u_rate (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.restart(restart),
		.mode(mode),
		.fast(shift_mode ? mp : dbl_ff),
		.baud_div(baud_ff),
		.tick(tick)
	);

	// control register: hardware set wins over a software write
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_fe = fe_ff;
		if (wr_ctrl) begin
			nxt_ctrl = spz_ctrl_t'(wdat);
			if (fesel_ff) begin
				nxt_ctrl.mode_select_high = ctrl_ff.mode_select_high;
				nxt_fe = wdat[7];
			end
		end
		if (tx_done_set) begin
			nxt_ctrl.tx_done_flag = 1'b1;
		end
		if (rx_accept) begin
			nxt_ctrl.rx_done_flag = 1'b1;
		end
		if (rx_accept && rx9_load) begin
			nxt_ctrl.rx_ninth_bit = rx9_val;
		end
		if (fe_set) begin
			nxt_fe = 1'b1;
		end
	end

	assign events = '{frame_err: fe_set, rx_done: rx_accept, tx_done: tx_done_set};
	assign irq = |(stat_ff & mask_ff);

	// transmitter sequencing
	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_tx_sr = tx_sr_ff;
		nxt_tx_bit = tx_bit_ff;
		nxt_tx_sub = tx_sub_ff;
		nxt_tx_phase = tx_phase_ff;
		tx_done_set = 1'b0;
		unique case (tx_state_ff)
			SPZ_TX_IDLE: begin
				if (tx_start) begin
					nxt_tx_bit = 4'h0;
					nxt_tx_sub = 4'h0;
					nxt_tx_phase = 1'b0;
					if (shift_mode) begin
						nxt_tx_sr = {3'h7, wdat};
						nxt_tx_state = SPZ_TX_SYNC;
					end else begin
						nxt_tx_sr = {1'b1, tx_ninth, wdat, 1'b0};
						nxt_tx_state = SPZ_TX_ASYNC;
					end
				end
			end
			SPZ_TX_ASYNC: begin
				if (tick) begin
					nxt_tx_sub = tx_sub_ff + 4'h1;
					if (tx_sub_ff == 4'hF) begin
						nxt_tx_sr = {1'b1, tx_sr_ff[10:1]};
						nxt_tx_bit = tx_bit_ff + 4'h1;
						tx_done_set = (tx_bit_ff + 4'h1 == tx_last);
						if (tx_bit_ff == tx_last) begin
							nxt_tx_state = SPZ_TX_IDLE;
						end
					end
				end
			end
			SPZ_TX_SYNC: begin
				if (tick) begin
					nxt_tx_phase = ~tx_phase_ff;
					if (tx_phase_ff) begin
						nxt_tx_sr = {1'b1, tx_sr_ff[10:1]};
						nxt_tx_bit = tx_bit_ff + 4'h1;
						if (tx_bit_ff == 4'h7) begin
							tx_done_set = 1'b1;
							nxt_tx_state = SPZ_TX_IDLE;
						end
					end
				end
			end
			default: begin
				nxt_tx_state = SPZ_TX_IDLE;
			end
		endcase
	end

	// receiver sequencing
	always_comb begin
		rx_frame = rx_bits_ff;
		rx_frame[rx_bit_ff] = rxd_s2_ff;
		nxt_rx_state = rx_state_ff;
		nxt_rx_bits = rx_bits_ff;
		nxt_rx_bit = rx_bit_ff;
		nxt_rx_sub = rx_sub_ff;
		nxt_rx_phase = rx_phase_ff;
		rx_finish = 1'b0;
		unique case (rx_state_ff)
			SPZ_RX_IDLE: begin
				nxt_rx_bit = 4'h0;
				nxt_rx_sub = 4'h0;
				nxt_rx_phase = 1'b0;
				if (rx_sync_start) begin
					nxt_rx_state = SPZ_RX_SYNC;
				end else if (rx_async_start) begin
					nxt_rx_state = SPZ_RX_START;
				end
			end
			SPZ_RX_START: begin
				if (!ren) begin
					nxt_rx_state = SPZ_RX_IDLE;
				end else if (tick) begin
					nxt_rx_sub = rx_sub_ff + 4'h1;
					// mid start bit: a high level is a glitch
					if (rx_sub_ff == 4'h7) begin
						nxt_rx_sub = 4'h0;
						nxt_rx_state = rxd_s2_ff ? SPZ_RX_IDLE : SPZ_RX_ASYNC;
					end
				end
			end
			SPZ_RX_ASYNC: begin
				if (!ren) begin
					nxt_rx_state = SPZ_RX_IDLE;
				end else if (tick) begin
					nxt_rx_sub = rx_sub_ff + 4'h1;
					if (rx_sub_ff == 4'hF) begin
						nxt_rx_bits = rx_frame;
						nxt_rx_bit = rx_bit_ff + 4'h1;
						if (rx_bit_ff == rx_last) begin
							rx_finish = 1'b1;
							nxt_rx_state = SPZ_RX_IDLE;
						end
					end
				end
			end
			SPZ_RX_SYNC: begin
				if (!ren) begin
					nxt_rx_state = SPZ_RX_IDLE;
				end else if (tick) begin
					nxt_rx_phase = ~rx_phase_ff;
					// sample at the rising shift clock edge
					if (!rx_phase_ff) begin
						nxt_rx_bits = rx_frame;
					end else begin
						nxt_rx_bit = rx_bit_ff + 4'h1;
						if (rx_bit_ff == 4'h7) begin
							rx_finish = 1'b1;
							nxt_rx_state = SPZ_RX_IDLE;
						end
					end
				end
			end
		endcase
	end

	// pins: in mode 0 txd carries the shift clock, rxd the data
	always_comb begin
		nxt_txd = 1'b1;
		nxt_rxd_o = 1'b1;
		nxt_rxd_oe = 1'b0;
		if (tx_state_ff == SPZ_TX_SYNC) begin
			nxt_txd = tx_phase_ff;
			nxt_rxd_o = tx_sr_ff[0];
			nxt_rxd_oe = 1'b1;
		end else if (rx_state_ff == SPZ_RX_SYNC) begin
			nxt_txd = rx_phase_ff;
		end else if (tx_state_ff == SPZ_TX_ASYNC) begin
			nxt_txd = tx_sr_ff[0];
		end
	end

	assign txd = txd_ff;
	assign rxd_o = rxd_o_ff;
	assign rxd_oe = rxd_oe_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ack_ff <= 1'b0;
			readdata_ff <= 32'h0000_0000;
			ctrl_ff <= spz_ctrl_t'(`SPZ_CTRL_RST);
			fe_ff <= 1'b0;
			dbl_ff <= PWR_RST[`SPZ_PWR_DBL];
			fesel_ff <= PWR_RST[`SPZ_PWR_FESEL];
			baud_ff <= `SPZ_BAUD_RST;
			stat_ff <= spz_irq_t'(`SPZ_IRQ_RST);
			mask_ff <= spz_irq_t'(`SPZ_IRQ_RST);
		end else if (ce) begin
			ack_ff <= bus_req & ~ack_ff;
			if (rd_load) begin
				readdata_ff <= {24'h00_0000, rdata};
			end
			ctrl_ff <= nxt_ctrl;
			fe_ff <= nxt_fe;
			if (wr_take && hit_pwr) begin
				dbl_ff <= wdat[`SPZ_PWR_DBL];
				fesel_ff <= wdat[`SPZ_PWR_FESEL];
			end
			if (wr_take && hit_baud) begin
				baud_ff <= wdat;
			end
			if (wr_take && hit_mask) begin
				mask_ff <= spz_irq_t'(wdat[2:0]);
			end
			// write one clears; a new event wins
			stat_ff <= (stat_ff & ~((wr_take && hit_stat) ? spz_irq_t'(wdat[2:0]) : 3'h0))
				| events;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxbuf_ff <= 8'h00;
			rxd_s1_ff <= 1'b1;
			rxd_s2_ff <= 1'b1;
			rxd_prev_ff <= 1'b1;
			txd_ff <= 1'b1;
			rxd_o_ff <= 1'b1;
			rxd_oe_ff <= 1'b0;
		end else if (ce) begin
			rxd_s1_ff <= rxd_i;
			rxd_s2_ff <= rxd_s1_ff;
			rxd_prev_ff <= rxd_s2_ff;
			if (rx_accept) begin
				// mode 0 finishes half a shift clock after the last sample
				rxbuf_ff <= shift_mode ? rx_bits_ff[7:0] : rx_frame[7:0];
			end
			txd_ff <= nxt_txd;
			rxd_o_ff <= nxt_rxd_o;
			rxd_oe_ff <= nxt_rxd_oe;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_state_ff <= SPZ_TX_IDLE;
			tx_sr_ff <= 11'h7FF;
			tx_bit_ff <= 4'h0;
			tx_sub_ff <= 4'h0;
			tx_phase_ff <= 1'b0;
			rx_state_ff <= SPZ_RX_IDLE;
			rx_bits_ff <= 10'h000;
			rx_bit_ff <= 4'h0;
			rx_sub_ff <= 4'h0;
			rx_phase_ff <= 1'b0;
		end else if (ce) begin
			tx_state_ff <= nxt_tx_state;
			tx_sr_ff <= nxt_tx_sr;
			tx_bit_ff <= nxt_tx_bit;
			tx_sub_ff <= nxt_tx_sub;
			tx_phase_ff <= nxt_tx_phase;
			rx_state_ff <= nxt_rx_state;
			rx_bits_ff <= nxt_rx_bits;
			rx_bit_ff <= nxt_rx_bit;
			rx_sub_ff <= nxt_rx_sub;
			rx_phase_ff <= nxt_rx_phase;
		end
	end

endmodule : spz_serial_port

// >>> testbench/spz_checker.sv
`timescale 1ns/1ps
module spz_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic txd,
	input wire logic rxd_o,
	input wire logic rxd_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	wire req = avs_read | avs_write;
	wire done_rd = avs_read & ~avs_waitrequest;
	chk_one_wait: assert property (ce && req && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait state");
	chk_idle_wait: assert property (!req |-> !avs_waitrequest)
		else $error("waitrequest high without a request");
	chk_rd_upper: assert property (done_rd |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper lanes not zero");
	chk_rd_unmap: assert property (done_rd && avs_address == 10'h3FC |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_reset_idle: assert property ($rose(rst_n) |-> txd && !rxd_oe && !irq)
		else $error("outputs not idle after reset");
	chk_shift_half: assert property (
		rxd_oe && $fell(txd) |=> !txd ##1 (txd or (!txd [*4] ##1 txd)))
		else $error("shift clock low phase not 2 or 6 cycles");
	chk_shift_hold: assert property (
		rxd_oe && $past(rxd_oe) && txd && $past(txd) |-> $stable(rxd_o))
		else $error("shift data moved while shift clock high");
	chk_irq_fall: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest))
		else $error("interrupt dropped without a register write");
	cover property ($rose(irq));
	cover property ($rose(rxd_oe));
	cover property (done_rd && avs_readdata[0]);
endmodule : spz_checker

// >>> testbench/spz_line_model.sv
`timescale 1ns/1ps
module spz_line_model (
	input wire logic ref_clk,
	input wire logic txd,
	input wire logic flag,
	output logic drv
);
	logic fl_pre = 1'h0;
	logic fl_stop = 1'h0;
	logic [10:0] got = 11'h0;
	initial drv = 1'h1;
	task send(input logic [7:0] b, input logic n9, input logic st, input int nb, input int per);
		logic [10:0] f;
		f = (nb == 10) ? {1'h1, st, b, 1'h0} : {st, n9, b, 1'h0};
		for (int i = 0; i < nb; i++) begin
			if (i == nb - 1) fl_pre = flag;
			@(posedge ref_clk);
			drv <= f[i];
			repeat (per - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		fl_stop = flag;
		drv <= 1'h1;
	endtask : send
	task grab(input int nb, input int per);
		int w;
		w = 0;
		got = 11'h0;
		while (txd !== 1'h0 && w < 4000) begin
			@(posedge ref_clk);
			w++;
		end
		repeat (per / 2) @(posedge ref_clk);
		for (int i = 0; i < nb; i++) begin
			got[i] = txd;
			if (i == nb - 2) fl_pre = flag;
			fl_stop = flag;
			if (i < nb - 1) repeat (per) @(posedge ref_clk);
		end
	endtask : grab
endmodule : spz_line_model

// >>> testbench/spz_serial_port_test.sv
`timescale 1ns/1ps
`include "spz_regs.svh"
module spz_serial_port_test;
	localparam logic [7:0] a_ctl = `SPZ_IDX_CTRL;
	localparam logic [7:0] a_buf = `SPZ_IDX_BUF;
	localparam logic [7:0] a_pwr = `SPZ_IDX_PWR;
	localparam logic [7:0] a_bd = `SPZ_IDX_BAUD;
	localparam logic [7:0] a_st = `SPZ_IDX_IRQ_STAT;
	localparam logic [7:0] a_mk = `SPZ_IDX_IRQ_MASK;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic ce = 1'h1;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [9:0] avs_address = 10'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, irq, txd, rxd_o, rxd_oe, drv;
	wire rxd = rxd_oe ? rxd_o : drv;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [7:0] d;
	logic [5:0] f;
	logic [7:0] sh;
	logic [7:0] ra [6] = '{a_ctl, a_pwr, a_bd, a_st, a_mk, 8'hFF};
	logic [1:0] tm [4] = '{2'h1, 2'h2, 2'h2, 2'h3};
	logic [7:0] tp [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
	int tper [4] = '{16, 64, 32, 32};
	logic [1:0] rm [6] = '{2'h1, 2'h3, 2'h3, 2'h2, 2'h1, 2'h1};
	// mp, ren, ninth, stop, accepted, framing error
	logic [5:0] rf [6] = '{6'h16, 6'h34, 6'h3E, 6'h16, 6'h31, 6'h04};
	always #12.5 ref_clk = ~ref_clk;
	spz_serial_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .txd(txd), .rxd_i(rxd),
		.rxd_o(rxd_o), .rxd_oe(rxd_oe));
	spz_line_model line (.ref_clk(ref_clk), .txd(txd), .flag(irq), .drv(drv));
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		avs_address <= {a, 2'h0};
		avs_writedata <= {24'h0, v};
		avs_write <= 1'h1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
		avs_write <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		avs_address <= {a, 2'h0};
		avs_read <= 1'h1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'h0);
		v = avs_readdata[7:0];
		avs_read <= 1'h0;
	endtask : rd
	task ck(input logic [10:0] e, input logic [10:0] s, input string nm);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask : ck
	task rck(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
		rd(a, d);
		ck({3'h0, e}, {3'h0, d & m}, nm);
	endtask : rck
	task irq_ck(input logic e, input string nm);
		@(negedge ref_clk);
		ck({10'h0, e}, {10'h0, irq}, nm);
	endtask : irq_ck
	task stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'h1;
		foreach (ra[i]) rck(ra[i], 8'h00, 8'hFF, "reset value");
		wr(a_bd, 8'h5A);
		avs_byteenable <= 4'h0;
		wr(a_bd, 8'h00);
		avs_byteenable <= 4'hF;
		rck(a_bd, 8'h5A, 8'hFF, "baud divider");
		$display("test registers done");
		for (int i = 0; i < 2; i++) begin
			wr(a_ctl, {2'h0, i[0], 5'h0});
			wr(a_buf, 8'h3C);
			fork
				for (int k = 0; k < 8; k++) begin
					@(posedge txd);
					sh[k] = rxd_o;
				end
				begin
					repeat (i ? 24 : 72) @(posedge ref_clk);
					rck(a_ctl, 8'h00, 8'h02, "shift flag early");
					repeat (i ? 28 : 44) @(posedge ref_clk);
					rck(a_ctl, 8'h02, 8'h02, "shift flag");
				end
			join
			ck({3'h0, 8'h3C}, {3'h0, sh}, "shift data");
			wr(a_ctl, 8'h00);
		end
		wr(a_st, 8'h07);
		$display("test shift transmit done");
		wr(a_mk, 8'h01);
		for (int i = 0; i < 4; i++) begin
			wr(a_pwr, tp[i]);
			wr(a_bd, {7'h0, tm[i] == 2'h3});
			wr(a_ctl, {tm[i], 2'h0, i[0], 3'h0});
			wr(a_buf, 8'hC5 ^ i[7:0]);
			line.grab(tm[i] == 2'h1 ? 10 : 11, tper[i]);
			d = 8'hC5 ^ i[7:0];
			ck(tm[i] == 2'h1 ? {2'h1, d, 1'h0} : {1'h1, i[0], d, 1'h0}, line.got, "frame");
			ck(11'h1, {9'h0, line.fl_pre, line.fl_stop}, "tx flag timing");
			rck(a_ctl, 8'h02, 8'h02, "tx flag");
			repeat (tper[i]) @(posedge ref_clk);
			wr(a_mk, 8'h00);
			irq_ck(1'h0, "masked irq");
			wr(a_mk, 8'h01);
			irq_ck(1'h1, "unmasked irq");
			wr(a_st, 8'h01);
			irq_ck(1'h0, "cleared irq");
			wr(a_ctl, {tm[i], 6'h0});
		end
		$display("test async transmit done");
		wr(a_mk, 8'h02);
		for (int i = 0; i < 6; i++) begin
			f = rf[i];
			wr(a_pwr, 8'h00);
			wr(a_bd, {7'h0, rm[i] == 2'h3});
			wr(a_ctl, {rm[i], f[5], f[4], 4'h0});
			wr(a_pwr, {rm[i] == 2'h2, 7'h40});
			line.send(8'h96 ^ i[7:0], f[3], f[2], rm[i] == 2'h1 ? 10 : 11, rm[i] == 2'h1 ? 16 : 32);
			ck({10'h0, f[1]}, {9'h0, line.fl_pre, line.fl_stop}, "rx flag timing");
			rck(a_ctl, {f[0], 6'h0, f[1]}, 8'h81, "rx flags");
			if (f[1]) rck(a_ctl, {5'h0, rm[i] == 2'h1 ? f[2] : f[3], 2'h0}, 8'h04, "rx ninth");
			if (f[1]) rck(a_buf, 8'h96 ^ i[7:0], 8'hFF, "rx byte");
			repeat (50) @(posedge ref_clk);
			rck(a_ctl, {f[0], 6'h0, f[1]}, 8'h81, "flags held");
			wr(a_ctl, {1'h0, rm[i][0], f[5], f[4], 4'h0});
			rck(a_ctl, 8'h00, 8'h81, "flags cleared");
			wr(a_st, 8'h07);
		end
		$display("test receive done");
		wr(a_ctl, 8'h10);
		repeat (60) @(posedge ref_clk);
		rck(a_ctl, 8'h00, 8'h01, "shift rx flag early");
		repeat (60) @(posedge ref_clk);
		rck(a_ctl, 8'h01, 8'h01, "shift rx flag");
		rck(a_buf, 8'hFF, 8'hFF, "shift rx byte");
		wr(a_ctl, 8'h00);
		$display("test shift receive done");
		stop_test();
	end
endmodule : spz_serial_port_test
bind spz_serial_port spz_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
	.txd(txd), .rxd_o(rxd_o), .rxd_oe(rxd_oe));
